// ===== common/ssf_pkg.sv
package ssf_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] SSF_ADDR_CFG    = 8'h42;
	localparam logic [7:0] SSF_ADDR_SETTLE = 8'h43;
	localparam logic [7:0] SSF_CFG_RESET   = 8'h00;
	localparam logic [7:0] SSF_ST_RESET    = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int SSF_CFG_INTERVAL_TRIGGER_BIT  = 7;
	localparam int SSF_CFG_ITEN_BIT   = 6;
	localparam int SSF_CFG_FILTER_ENABLE_BIT  = 2;
	localparam int SSF_CFG_CUT_MSB    = 1;
	localparam int SSF_CFG_CUT_LSB    = 0;
	localparam int SSF_ST_SUB_MSB     = 7;
	localparam int SSF_ST_SUB_LSB     = 4;
	localparam int SSF_ST_INIT_MSB    = 3;
	localparam int SSF_ST_INIT_LSB    = 0;

	// ----------------------------------------------------------------
	// Cut-off encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] SSF_CUT_250HZ  = 2'h0;
	localparam logic [1:0] SSF_CUT_500HZ  = 2'h1;
	localparam logic [1:0] SSF_CUT_1000HZ = 2'h2;
	localparam logic [1:0] SSF_CUT_2000HZ = 2'h3;

	// ----------------------------------------------------------------
	// Delay tables in oscillator cycles
	// ----------------------------------------------------------------
	localparam int SSF_CNT_W = 9;
	typedef logic [SSF_CNT_W-1:0] ssf_cnt_t;
	localparam ssf_cnt_t SSF_SUB_CYC [16] = '{
		9'h008, 9'h00a, 9'h00d, 9'h010, 9'h014, 9'h019, 9'h020, 9'h028,
		9'h033, 9'h040, 9'h051, 9'h066, 9'h080, 9'h0a1, 9'h0cb, 9'h100};
	localparam ssf_cnt_t SSF_INIT_CYC [16] = '{
		9'h00d, 9'h010, 9'h014, 9'h019, 9'h020, 9'h028, 9'h033, 9'h040,
		9'h051, 9'h066, 9'h080, 9'h0a1, 9'h0cb, 9'h100, 9'h143, 9'h196};

	// ----------------------------------------------------------------
	// Sequencer states, Gray along idle -> initial -> subsequent
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SSF_IDLE = 2'b00,
		SSF_INIT = 2'b01,
		SSF_SUBS = 2'b11
	} ssf_state_e;

endpackage

// ===== verilog/ssf_top.sv
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
// Contract
// - A one written to the interval trigger bit starts interval timing only in low-power direct mode with the interval feature enabled, and the bit clears itself.
// - The write-only interval trigger enable bit 6 turns the interval function on, and is zero after reset.
// - The filter enable bit routes samples through the low-pass filter when one and bypasses it when zero.
// - With the filter enabled the cut-off field selects 250, 500, 1000 or 2000 Hz for codes 00 to 11.
// - While the filter is disabled, writes to the cut-off field have no effect and the filter stays bypassed.
// - The upper nibble of the settling register picks the subsequent sample delay from 8 to 256 oscillator cycles.
// - The lower nibble picks the initial sample delay from 13 to 406 oscillator cycles.
// - In low-power direct mode the sequencer starts on entry, or only on a trigger write if interval is enabled, then triggers captures while the mode lasts.
module ssf_top
	import ssf_pkg::*;
(
	input  wire logic       I_CLK,
	input  wire logic       I_RESETN,
	input  wire logic [7:0] I_ADDR,
	input  wire logic [7:0] I_WDATA,
	input  wire logic       I_WR,
	input  wire logic       I_RD,
	input  wire logic       I_LOW_POWER_DIRECT_MODE,
	input  wire logic       I_MFO_CLK,
	output logic      [7:0] O_RDATA,
	output logic            O_ADC_TRIG,
	output logic            O_FILTER_EN,
	output logic      [1:0] O_FILTER_CUTOFF,
	output logic            O_SEQ_BUSY
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	logic       wr_cfg;
	logic       wr_st;
	logic       interval_trigger_wr;
	assign wr_cfg   = I_WR && hit(I_ADDR, SSF_ADDR_CFG);
	assign wr_st    = I_WR && hit(I_ADDR, SSF_ADDR_SETTLE);
	assign interval_trigger_wr = wr_cfg && I_WDATA[SSF_CFG_INTERVAL_TRIGGER_BIT];

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic       iten_reg;
	logic       filter_enable_reg;
	logic [1:0] cut_reg;
	logic [3:0] sub_sel_reg;
	logic [3:0] init_sel_reg;

	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			iten_reg  <= SSF_CFG_RESET[SSF_CFG_ITEN_BIT];
			filter_enable_reg <= SSF_CFG_RESET[SSF_CFG_FILTER_ENABLE_BIT];
			cut_reg   <= SSF_CFG_RESET[SSF_CFG_CUT_MSB:SSF_CFG_CUT_LSB];
		end else if (wr_cfg) begin
			iten_reg  <= I_WDATA[SSF_CFG_ITEN_BIT];
			filter_enable_reg <= I_WDATA[SSF_CFG_FILTER_ENABLE_BIT];
			if (I_WDATA[SSF_CFG_FILTER_ENABLE_BIT]) begin
				cut_reg <= I_WDATA[SSF_CFG_CUT_MSB:SSF_CFG_CUT_LSB];
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			sub_sel_reg  <= SSF_ST_RESET[SSF_ST_SUB_MSB:SSF_ST_SUB_LSB];
			init_sel_reg <= SSF_ST_RESET[SSF_ST_INIT_MSB:SSF_ST_INIT_LSB];
		end else if (wr_st) begin
			sub_sel_reg  <= I_WDATA[SSF_ST_SUB_MSB:SSF_ST_SUB_LSB];
			init_sel_reg <= I_WDATA[SSF_ST_INIT_MSB:SSF_ST_INIT_LSB];
		end
	end

	// ----------------------------------------------------------------
	// Read port, trigger and interval enable bits read as zero
	// ----------------------------------------------------------------
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_RDATA <= 8'h00;
		end else if (I_RD && hit(I_ADDR, SSF_ADDR_CFG)) begin
			O_RDATA <= {5'h00, filter_enable_reg, cut_reg};
		end else if (I_RD && hit(I_ADDR, SSF_ADDR_SETTLE)) begin
			O_RDATA <= {sub_sel_reg, init_sel_reg};
		end else begin
			O_RDATA <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Filter controls, bypass forces the cut-off output to reset code
	// ----------------------------------------------------------------
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_FILTER_EN     <= 1'b0;
			O_FILTER_CUTOFF <= SSF_CUT_250HZ;
		end else begin
			O_FILTER_EN     <= filter_enable_reg;
			O_FILTER_CUTOFF <= filter_enable_reg ? cut_reg : SSF_CUT_250HZ;
		end
	end

	// ----------------------------------------------------------------
	// Oscillator edge detect
	// ----------------------------------------------------------------
	logic mfo_s1_reg;
	logic mfo_s2_reg;
	logic mfo_s3_reg;
	logic mfo_edge;

	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			mfo_s1_reg <= 1'b0;
			mfo_s2_reg <= 1'b0;
			mfo_s3_reg <= 1'b0;
		end else begin
			mfo_s1_reg <= I_MFO_CLK;
			mfo_s2_reg <= mfo_s1_reg;
			mfo_s3_reg <= mfo_s2_reg;
		end
	end
	// Only the second and third flops feed logic, the first may be metastable
	assign mfo_edge = mfo_s2_reg && !mfo_s3_reg;

	// ----------------------------------------------------------------
	// Capture sequencer
	// ----------------------------------------------------------------
	ssf_state_e state_reg;
	ssf_state_e state_next;
	ssf_cnt_t   cnt_reg;
	ssf_cnt_t   cnt_next;
	logic       trig_next;
	logic       low_power_direct_mode_d_reg;
	logic       start;

	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			low_power_direct_mode_d_reg <= 1'b0;
		end else begin
			low_power_direct_mode_d_reg <= I_LOW_POWER_DIRECT_MODE;
		end
	end

	// Interval mode waits for the trigger write, otherwise entry starts it
	assign start = I_LOW_POWER_DIRECT_MODE && (iten_reg ? interval_trigger_wr : !low_power_direct_mode_d_reg);

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		trig_next  = 1'b0;
		if (!I_LOW_POWER_DIRECT_MODE) begin
			state_next = SSF_IDLE;
			cnt_next   = '0;
		end else begin
			unique case (state_reg)
				SSF_IDLE: begin
					if (start) begin
						state_next = SSF_INIT;
						cnt_next   = SSF_INIT_CYC[init_sel_reg];
					end
				end
				SSF_INIT, SSF_SUBS: begin
					if (mfo_edge) begin
						if (cnt_reg == ssf_cnt_t'(1)) begin
							trig_next  = 1'b1;
							state_next = SSF_SUBS;
							cnt_next   = SSF_SUB_CYC[sub_sel_reg];
						end else begin
							cnt_next = cnt_reg - ssf_cnt_t'(1);
						end
					end
				end
				default: begin
					state_next = SSF_IDLE;
					cnt_next   = '0;
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			state_reg  <= SSF_IDLE;
			cnt_reg    <= '0;
			O_ADC_TRIG <= 1'b0;
			O_SEQ_BUSY <= 1'b0;
		end else begin
			state_reg  <= state_next;
			cnt_reg    <= cnt_next;
			O_ADC_TRIG <= trig_next;
			O_SEQ_BUSY <= state_next != SSF_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RESETN);

	sequence seq_enter_init;
		state_reg == SSF_IDLE ##1 state_reg == SSF_INIT;
	endsequence

	sequence seq_last_tick;
		state_reg != SSF_IDLE && mfo_edge && cnt_reg == ssf_cnt_t'(1) && I_LOW_POWER_DIRECT_MODE;
	endsequence

	chk_interval_trigger_start: assert property (
		state_reg == SSF_IDLE && interval_trigger_wr && I_LOW_POWER_DIRECT_MODE && iten_reg |=> state_reg == SSF_INIT)
		else $error("interval trigger did not start timing");

	chk_interval_trigger_gated: assert property (
		state_reg == SSF_IDLE && iten_reg && !interval_trigger_wr |=> state_reg == SSF_IDLE)
		else $error("timing started without interval trigger");

	chk_iten_source: assert property (
		$rose(iten_reg) |-> $past(wr_cfg && I_WDATA[SSF_CFG_ITEN_BIT]))
		else $error("interval enable set without a write");

	chk_filter_path: assert property (
		wr_cfg && I_WDATA[SSF_CFG_FILTER_ENABLE_BIT] ##1 !wr_cfg |=> O_FILTER_EN)
		else $error("filter enable not passed to output");

	chk_cutoff_load: assert property (
		wr_cfg && I_WDATA[SSF_CFG_FILTER_ENABLE_BIT] |=> cut_reg == $past(I_WDATA[1:0]))
		else $error("cut-off not loaded");

	chk_cutoff_hold: assert property (
		wr_cfg && !I_WDATA[SSF_CFG_FILTER_ENABLE_BIT] |=> $stable(cut_reg) ##1 O_FILTER_CUTOFF == SSF_CUT_250HZ)
		else $error("cut-off changed while filter bypassed");

	chk_delay_load: assert property (
		seq_enter_init |-> cnt_reg == SSF_INIT_CYC[$past(init_sel_reg)])
		else $error("initial delay count wrong");

	chk_trig_pulse: assert property (
		seq_last_tick |=> O_ADC_TRIG && state_reg == SSF_SUBS && cnt_reg == SSF_SUB_CYC[$past(sub_sel_reg)])
		else $error("capture trigger or reload missing");

	chk_auto_stop: assert property (
		!I_LOW_POWER_DIRECT_MODE |=> state_reg == SSF_IDLE && !O_SEQ_BUSY && !O_ADC_TRIG)
		else $error("sequencer ran outside direct mode");

	// Register bus and filter outputs
	chk_cfg_wonly: assert property (
		I_RD && I_ADDR == SSF_ADDR_CFG |=> !O_RDATA[SSF_CFG_INTERVAL_TRIGGER_BIT] && !O_RDATA[SSF_CFG_ITEN_BIT])
		else $error("write-only config bits read back");

	chk_settle_load: assert property (
		wr_st |=> {sub_sel_reg, init_sel_reg} == $past(I_WDATA))
		else $error("settling selects not loaded");

	chk_settle_read: assert property (
		I_RD && I_ADDR == SSF_ADDR_SETTLE |=> O_RDATA == {$past(sub_sel_reg), $past(init_sel_reg)})
		else $error("settling register read wrong");

	chk_filter_off: assert property (
		wr_cfg && !I_WDATA[SSF_CFG_FILTER_ENABLE_BIT] ##1 !wr_cfg |=> !O_FILTER_EN)
		else $error("filter not bypassed after disable");

	chk_bypass_code: assert property (
		!O_FILTER_EN |-> O_FILTER_CUTOFF == SSF_CUT_250HZ)
		else $error("cut-off code shown while bypassed");

	// Sequencer
	chk_auto_entry: assert property (
		state_reg == SSF_IDLE && I_LOW_POWER_DIRECT_MODE && !low_power_direct_mode_d_reg && !iten_reg |=> state_reg == SSF_INIT)
		else $error("mode entry did not start the sequencer");

	chk_interval_trigger_ignored: assert property (
		state_reg == SSF_SUBS && I_LOW_POWER_DIRECT_MODE && interval_trigger_wr |=> state_reg == SSF_SUBS)
		else $error("trigger write disturbed a running sequence");

	chk_busy_state: assert property (
		O_SEQ_BUSY == (state_reg != SSF_IDLE))
		else $error("busy flag disagrees with sequencer state");

	chk_state_legal: assert property (
		state_reg inside {SSF_IDLE, SSF_INIT, SSF_SUBS})
		else $error("sequencer in unused state code");

	chk_cnt_hold: assert property (
		state_reg != SSF_IDLE && I_LOW_POWER_DIRECT_MODE && !mfo_edge |=> $stable(cnt_reg))
		else $error("delay count moved without an oscillator edge");

	chk_cnt_step: assert property (
		state_reg != SSF_IDLE && I_LOW_POWER_DIRECT_MODE && mfo_edge && cnt_reg > 9'h001 |=> cnt_reg == $past(cnt_reg) - 9'h001)
		else $error("delay count did not step down");

	chk_trig_single: assert property (
		O_ADC_TRIG |=> !O_ADC_TRIG)
		else $error("capture trigger longer than one cycle");

	chk_trig_source: assert property (
		O_ADC_TRIG |-> $past(mfo_edge) && $past(cnt_reg) == 9'h001)
		else $error("trigger without the last delay tick");

endmodule // ssf_top

// ===== testbench/test_sensor_sample_timing_filter_cfg.sv
`timescale 1ns/1ps
module test_sensor_sample_timing_filter_cfg
	import ssf_pkg::*;
;
	typedef struct {
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] r;
		logic       fe;
		logic [1:0] ct;
	} ssf_row_s;

	logic        clk = 1'b0;
	logic        resetn;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic        low_power_direct_mode;
	logic        medium_freq_oscillator = 1'b0;
	logic        mfo_q = 1'b0;
	logic        mfo_run;
	logic [3:0]  div = 4'h0;
	logic [15:0] edges = 16'h0000;
	logic [7:0]  rdata;
	logic        trig;
	logic        fen;
	logic [1:0]  fcut;
	logic        busy;
	int          mismatches;
	int          cmp_count;
	ssf_row_s    rows [7];

	ssf_top ssf_top_i (.I_CLK(clk), .I_RESETN(resetn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
		.I_RD(rd), .I_LOW_POWER_DIRECT_MODE(low_power_direct_mode), .I_MFO_CLK(medium_freq_oscillator), .O_RDATA(rdata), .O_ADC_TRIG(trig),
		.O_FILTER_EN(fen), .O_FILTER_CUTOFF(fcut), .O_SEQ_BUSY(busy));

	always #4 clk = ~clk;

	// ----------------------------------------------------------------
	// Oscillator stand-in, 16 clocks a period, still when stopped
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (mfo_run) begin
			div <= div + 4'h1;
		end else begin
			div <= 4'h0;
		end
		medium_freq_oscillator   <= mfo_run & div[3];
		mfo_q <= medium_freq_oscillator;
		if (medium_freq_oscillator & ~mfo_q) begin
			edges <= edges + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic complete_run;
		$display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		check({8'h00, rdata}, {8'h00, e});
		@(posedge clk);
	endtask

	task automatic wait_trig;
		int n;
		for (n = 0; n < 8000 && trig !== 1'b1; n++) begin
			@(posedge clk);
		end
		if (n == 8000) begin
			mismatches++;
			complete_run;
		end else begin
			@(posedge clk);
		end
	endtask

	// Oscillator edges before first and second capture
	task automatic measure(input logic [15:0] n_init, input logic [15:0] n_sub);
		logic [15:0] base;
		base = edges;
		mfo_run <= 1'b1;
		wait_trig;
		check(edges - base, n_init);
		base = edges;
		wait_trig;
		check(edges - base, n_sub);
	endtask

	task automatic busy_after(input int n, input logic exp);
		repeat (n) @(posedge clk);
		@(negedge clk);
		check({15'h0000, busy}, {15'h0000, exp});
		@(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		resetn = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		low_power_direct_mode = 1'b0;
		mfo_run = 1'b0;
		mismatches = 0;
		cmp_count = 0;
		rows = '{'{SSF_ADDR_CFG, 8'h07, 8'h07, 1'b1, 2'h3}, '{SSF_ADDR_CFG, 8'h05, 8'h05, 1'b1, 2'h1},
			'{SSF_ADDR_CFG, 8'hc6, 8'h06, 1'b1, 2'h2}, '{SSF_ADDR_CFG, 8'h01, 8'h02, 1'b0, 2'h0},
			'{SSF_ADDR_CFG, 8'h04, 8'h04, 1'b1, 2'h0}, '{SSF_ADDR_SETTLE, 8'ha5, 8'ha5, 1'b1, 2'h0},
			'{8'h44, 8'hff, 8'h00, 1'b1, 2'h0}};
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd_reg(SSF_ADDR_CFG, SSF_CFG_RESET);
		rd_reg(SSF_ADDR_SETTLE, SSF_ST_RESET);
		check({12'h000, fen, fcut, busy}, 16'h0000);
		foreach (rows[i]) begin
			wr_reg(rows[i].a, rows[i].d);
			rd_reg(rows[i].a, rows[i].r);
			check({13'h0000, fen, fcut}, {13'h0000, rows[i].fe, rows[i].ct});
		end
		// Automatic start on mode entry, shortest and longest delays
		wr_reg(SSF_ADDR_CFG, 8'h05);
		wr_reg(SSF_ADDR_SETTLE, 8'h00);
		low_power_direct_mode <= 1'b1;
		busy_after(2, 1'b1);
		measure(16'd13, 16'd8);
		low_power_direct_mode <= 1'b0;
		mfo_run <= 1'b0;
		busy_after(3, 1'b0);
		wr_reg(SSF_ADDR_SETTLE, 8'hff);
		low_power_direct_mode <= 1'b1;
		busy_after(2, 1'b1);
		measure(16'd406, 16'd256);
		low_power_direct_mode <= 1'b0;
		mfo_run <= 1'b0;
		busy_after(3, 1'b0);
		// Interval trigger gating
		wr_reg(SSF_ADDR_SETTLE, 8'h00);
		wr_reg(SSF_ADDR_CFG, 8'hc0);
		busy_after(3, 1'b0);
		low_power_direct_mode <= 1'b1;
		busy_after(4, 1'b0);
		wr_reg(SSF_ADDR_CFG, 8'h40);
		busy_after(4, 1'b0);
		wr_reg(SSF_ADDR_CFG, 8'hc0);
		busy_after(2, 1'b1);
		rd_reg(SSF_ADDR_CFG, 8'h01);
		check({13'h0000, fen, fcut}, 16'h0000);
		measure(16'd13, 16'd8);
		wr_reg(SSF_ADDR_CFG, 8'hc0);
		busy_after(2, 1'b1);
		low_power_direct_mode <= 1'b0;
		mfo_run <= 1'b0;
		busy_after(3, 1'b0);
		// Reset in mid-run clears registers and sequencer
		wr_reg(SSF_ADDR_CFG, 8'h07);
		wr_reg(SSF_ADDR_SETTLE, 8'h5a);
		low_power_direct_mode <= 1'b1;
		busy_after(2, 1'b1);
		mfo_run <= 1'b1;
		repeat (40) @(posedge clk);
		resetn <= 1'b0;
		low_power_direct_mode <= 1'b0;
		mfo_run <= 1'b0;
		@(posedge clk);
		check({11'h000, fen, fcut, busy, trig}, 16'h0000);
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		check({11'h000, fen, fcut, busy, trig}, 16'h0000);
		rd_reg(SSF_ADDR_CFG, SSF_CFG_RESET);
		rd_reg(SSF_ADDR_SETTLE, SSF_ST_RESET);
		complete_run;
	end
endmodule // test_sensor_sample_timing_filter_cfg
